// ===== pkg/tpio_pkg.sv
package tpio_pkg;
  // register indices on the plain register port (byte-free, one register per address)
  localparam logic [3:0] ADDR_IOC_CH1 = 4'h0;
  localparam logic [3:0] ADDR_IOL_CH0 = 4'h1;
  localparam logic [3:0] ADDR_IOL_CH3 = 4'h2;
  localparam logic [3:0] ADDR_IOL_CH4 = 4'h3;
  localparam logic [3:0] ADDR_IOU_CH5 = 4'h4;
  localparam logic [3:0] ADDR_IOV_CH5 = 4'h5;
  localparam logic [3:0] ADDR_IOW_CH5 = 4'h6;
  localparam logic [3:0] ADDR_CNT = 4'h7;
  localparam logic [3:0] ADDR_GRA1 = 4'h8;
  localparam logic [3:0] ADDR_GRA0 = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  localparam logic [3:0] ADDR_MASK = 4'hB;
  localparam logic [3:0] ADDR_RUN = 4'hC;
  localparam logic [3:0] ADDR_MODE0 = 4'hD;
  // field layout
  localparam int IOC_D_LSB = 4;
  localparam int IOC_C_LSB = 0;
  localparam logic [7:0] CH5_FIELD_MASK = 8'h1F;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  // status bits
  localparam int ST_MATCH1 = 0;
  localparam int ST_CAPT1 = 1;
  localparam int ST_MATCH0 = 2;
  localparam int ST_WIDTH = 3;
  // synchroniser depth for the pin input
  localparam int SYNC_STAGES = 3;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } tpio_bus_s;
  typedef enum logic [1:0] {
    TPIO_CMP,
    TPIO_CAP_EDGE,
    TPIO_CAP_CH0
  } tpio_mode_e;
endpackage

// ===== rtl/tpio_pin_sync.sv
// three-stage synchroniser with edge detect on disagreement of stages two and three
module tpio_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin and results
  input wire logic pinIn,
  output logic pinLevel,
  output logic riseEvt,
  output logic fallEvt
);
  logic [tpio_pkg::SYNC_STAGES-1:0] stage_ff;

  // stage 0 feeds only stage 1; edges come from stages 1 and 2
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= {stage_ff[tpio_pkg::SYNC_STAGES-2:0], pinIn};
    end
  end

  assign pinLevel = stage_ff[2];
  assign riseEvt = stage_ff[1] & ~stage_ff[2];
  assign fallEvt = ~stage_ff[1] & stage_ff[2];
endmodule

// ===== rtl/tpio_top.sv
// Behaviour
// - code 0011/0111: toggle pin on match
// - code 0x01: drive low on match
// - code 0x10: drive high on match
// - 0000/0100 retain; low after reset
// - code 1000: capture counter on rising edge
// - code 1001: capture counter on falling edge
// - code 101x: capture on both edges
// - code 11xx: capture on channel-0 event
// - low control regs: D field 7:4, C 3:0
// - channel-5 regs: 5-bit field, top reads zero
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
module tpio_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire tpio_pkg::tpio_bus_s busReq,
  output logic [15:0] rdData,
  // timer pins
  input wire logic ch1PinAIn,
  output logic ch1PinAOut,
  output logic ch1PinAOe_n,
  // interrupt
  output logic irq
);
  logic [3:0] ioCtrlA_ff;
  logic [7:0] ioLow_ff [3];
  logic [4:0] ioCh5_ff [3];
  logic [15:0] count_ff;
  logic [15:0] grA1_ff;
  logic [15:0] grA0_ff;
  logic ch0Capture_ff;
  logic run_ff;
  logic [tpio_pkg::ST_WIDTH-1:0] status_ff;
  logic [tpio_pkg::ST_WIDTH-1:0] mask_ff;
  logic pinOut_ff;
  logic [15:0] rdData_ff;
  logic pinLevel;
  logic riseEvt;
  logic fallEvt;
  logic match1;
  logic match0;
  logic capEvt;
  logic ch0Evt;
  logic ioWrite;
  logic [tpio_pkg::ST_WIDTH-1:0] evtVec;
  logic [1:0] nxt_pinOut;
  tpio_pkg::tpio_mode_e mode;

  // decode of the 4-bit code into its broad mode
  function automatic tpio_pkg::tpio_mode_e decodeMode(input logic [3:0] code);
    if (!code[3]) begin
      decodeMode = tpio_pkg::TPIO_CMP;
    end else if (code[2]) begin
      decodeMode = tpio_pkg::TPIO_CAP_CH0;
    end else begin
      decodeMode = tpio_pkg::TPIO_CAP_EDGE;
    end
  endfunction

  tpio_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(ch1PinAIn),
    .pinLevel(pinLevel),
    .riseEvt(riseEvt),
    .fallEvt(fallEvt)
  );

  assign mode = decodeMode(ioCtrlA_ff);
  assign ioWrite = busReq.wr && (busReq.addr == tpio_pkg::ADDR_IOC_CH1);
  // match only counts while the counter runs, so a stopped timer stays quiet
  assign match1 = run_ff && (count_ff == grA1_ff) && (mode == tpio_pkg::TPIO_CMP);
  assign match0 = run_ff && (count_ff == grA0_ff) && !ch0Capture_ff;
  // channel 0 capture source: counter value reaching its register also serves
  assign ch0Evt = match0 || (ch0Capture_ff && run_ff && count_ff == grA0_ff);

  // capture source selection per code
  always_comb begin
    capEvt = 1'b0;
    case (mode)
      tpio_pkg::TPIO_CAP_EDGE: begin
        if (ioCtrlA_ff[1]) begin
          capEvt = riseEvt | fallEvt;
        end else if (ioCtrlA_ff[0]) begin
          capEvt = fallEvt;
        end else begin
          capEvt = riseEvt;
        end
      end
      tpio_pkg::TPIO_CAP_CH0: capEvt = ch0Evt;
      default: capEvt = 1'b0;
    endcase
  end

  // next pin level: bit 1 flags a loaded value, bit 0 the level
  always_comb begin
    nxt_pinOut = {1'b0, pinOut_ff};
    if (ioWrite && !busReq.wdata[3]) begin
      // writing a compare code other than 0000/0100 sets the initial level from bit 2
      if (busReq.wdata[1:0] != 2'b00) begin
        nxt_pinOut = {1'b1, busReq.wdata[2]};
      end
    end else if (match1) begin
      case (ioCtrlA_ff[1:0])
        2'b01: nxt_pinOut = 2'b10;
        2'b10: nxt_pinOut = 2'b11;
        2'b11: nxt_pinOut = {1'b1, ~pinOut_ff};
        default: nxt_pinOut = {1'b0, pinOut_ff};
      endcase
    end
  end

  // pin output register; low out of reset until configured
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut_ff <= 1'b0;
    end else begin
      pinOut_ff <= nxt_pinOut[0];
    end
  end

  // pin drives only in compare mode; enable is active low
  assign ch1PinAOut = pinOut_ff;
  assign ch1PinAOe_n = (mode != tpio_pkg::TPIO_CMP);

  // channel 1 code register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ioCtrlA_ff <= tpio_pkg::IO_RST[3:0];
    end else if (ioWrite) begin
      ioCtrlA_ff <= busReq.wdata[3:0];
    end
  end

  // low control registers for channels 0, 3, 4 and channel-5 registers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_io
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ioLow_ff[gi] <= tpio_pkg::IO_RST;
          ioCh5_ff[gi] <= tpio_pkg::IO_RST[4:0];
        end else if (busReq.wr) begin
          if (busReq.addr == 4'(tpio_pkg::ADDR_IOL_CH0 + gi)) begin
            ioLow_ff[gi] <= busReq.wdata[7:0];
          end
          if (busReq.addr == 4'(tpio_pkg::ADDR_IOU_CH5 + gi)) begin
            ioCh5_ff[gi] <= busReq.wdata[4:0];
          end
        end
      end
    end
  endgenerate

  // counter, run control and channel 0 mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= tpio_pkg::CNT_RST;
      run_ff <= 1'b0;
      ch0Capture_ff <= 1'b0;
    end else begin
      if (busReq.wr && busReq.addr == tpio_pkg::ADDR_CNT) begin
        count_ff <= busReq.wdata;
      end else if (run_ff) begin
        count_ff <= count_ff + 16'h0001;
      end
      if (busReq.wr && busReq.addr == tpio_pkg::ADDR_RUN) begin
        run_ff <= busReq.wdata[0]; // restart comes last in the recovery order
      end
      if (busReq.wr && busReq.addr == tpio_pkg::ADDR_MODE0) begin
        ch0Capture_ff <= busReq.wdata[0];
      end
    end
  end

  // general register A of channel 1: written by software or by capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grA1_ff <= tpio_pkg::GR_RST;
    end else if (capEvt) begin
      grA1_ff <= count_ff; // capture beats a same-cycle write
    end else if (busReq.wr && busReq.addr == tpio_pkg::ADDR_GRA1) begin
      grA1_ff <= busReq.wdata;
    end
  end

  // general register A of channel 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grA0_ff <= tpio_pkg::GR_RST;
    end else if (busReq.wr && busReq.addr == tpio_pkg::ADDR_GRA0) begin
      grA0_ff <= busReq.wdata;
    end
  end

  assign evtVec = {ch0Evt, capEvt, match1};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_ff <= '0;
    end else if (busReq.wr && busReq.addr == tpio_pkg::ADDR_STATUS) begin
      status_ff <= (status_ff & ~busReq.wdata[tpio_pkg::ST_WIDTH-1:0]) | evtVec;
    end else begin
      status_ff <= status_ff | evtVec;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= '0;
    end else if (busReq.wr && busReq.addr == tpio_pkg::ADDR_MASK) begin
      mask_ff <= busReq.wdata[tpio_pkg::ST_WIDTH-1:0];
    end
  end

  // combine: flag and request appear together the edge after the match
  assign irq = |(status_ff & mask_ff);

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_ff <= 16'h0000;
    end else if (busReq.rd) begin
      case (busReq.addr)
        tpio_pkg::ADDR_IOC_CH1: rdData_ff <= {12'h000, ioCtrlA_ff};
        tpio_pkg::ADDR_IOL_CH0: rdData_ff <= {8'h00, ioLow_ff[0]};
        tpio_pkg::ADDR_IOL_CH3: rdData_ff <= {8'h00, ioLow_ff[1]};
        tpio_pkg::ADDR_IOL_CH4: rdData_ff <= {8'h00, ioLow_ff[2]};
        tpio_pkg::ADDR_IOU_CH5: rdData_ff <= {11'h000, ioCh5_ff[0]};
        tpio_pkg::ADDR_IOV_CH5: rdData_ff <= {11'h000, ioCh5_ff[1]};
        tpio_pkg::ADDR_IOW_CH5: rdData_ff <= {11'h000, ioCh5_ff[2]};
        tpio_pkg::ADDR_CNT: rdData_ff <= count_ff;
        tpio_pkg::ADDR_GRA1: rdData_ff <= grA1_ff;
        tpio_pkg::ADDR_GRA0: rdData_ff <= grA0_ff;
        tpio_pkg::ADDR_STATUS: rdData_ff <= {13'h0000, status_ff};
        tpio_pkg::ADDR_MASK: rdData_ff <= {13'h0000, mask_ff};
        tpio_pkg::ADDR_RUN: rdData_ff <= {15'h0000, run_ff};
        tpio_pkg::ADDR_MODE0: rdData_ff <= {15'h0000, ch0Capture_ff};
        default: rdData_ff <= 16'h0000;
      endcase
    end else begin
      rdData_ff <= 16'h0000;
    end
  end
  assign rdData = rdData_ff;

  // assertions
  a_toggle_on_match: assert property (@(posedge clk) disable iff (sys_rst)
    match1 && !ioWrite && ioCtrlA_ff[1:0] == 2'b11 |=> pinOut_ff != $past(pinOut_ff))
    else $error("pin did not toggle on match");
  a_low_on_match: assert property (@(posedge clk) disable iff (sys_rst)
    match1 && !ioWrite && ioCtrlA_ff[1:0] == 2'b01 |=> !pinOut_ff)
    else $error("pin not low after match");
  a_high_on_match: assert property (@(posedge clk) disable iff (sys_rst)
    match1 && !ioWrite && ioCtrlA_ff[1:0] == 2'b10 |=> pinOut_ff)
    else $error("pin not high after match");
  a_retain_level: assert property (@(posedge clk) disable iff (sys_rst)
    !ioWrite && ioCtrlA_ff[1:0] == 2'b00 && !ioCtrlA_ff[3] |=> $stable(pinOut_ff))
    else $error("pin changed in retain mode");
  a_rise_capture: assert property (@(posedge clk) disable iff (sys_rst)
    ioCtrlA_ff == 4'h8 && riseEvt |=> grA1_ff == $past(count_ff))
    else $error("rising edge capture missed");
  a_fall_capture: assert property (@(posedge clk) disable iff (sys_rst)
    ioCtrlA_ff == 4'h9 && fallEvt |=> grA1_ff == $past(count_ff))
    else $error("falling edge capture missed");
  a_both_capture: assert property (@(posedge clk) disable iff (sys_rst)
    ioCtrlA_ff[3:1] == 3'b101 && (riseEvt || fallEvt) |=> grA1_ff == $past(count_ff))
    else $error("both edge capture missed");
  a_ch0_capture: assert property (@(posedge clk) disable iff (sys_rst)
    ioCtrlA_ff[3:2] == 2'b11 && ch0Evt |=> grA1_ff == $past(count_ff))
    else $error("channel 0 linked capture missed");
  a_flag_irq: assert property (@(posedge clk) disable iff (sys_rst)
    match1 && mask_ff[tpio_pkg::ST_MATCH1] |=> status_ff[tpio_pkg::ST_MATCH1] && irq)
    else $error("match flag or interrupt missing");
endmodule

// ===== tb/timer_pin_io_control_bench.sv
module timer_pin_io_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic sys_rst;
  tpio_pkg::tpio_bus_s busReq;
  logic [15:0] rdData;
  logic pinIn;
  logic pinOut;
  logic pinOeN;
  logic irq;
  int errCount;
  int totalChecks;
  int cycles;
  // compare codes with {level before match, level after match}
  logic [3:0] cmpCode [8] = '{4'h1, 4'h5, 4'h3, 4'h7, 4'h6, 4'h2, 4'h4, 4'h0};
  logic [1:0] cmpExp [8] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3};
  // capture codes with {captures on rise, captures on fall}
  logic [3:0] capCode [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
  logic [1:0] capExp [6] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0};

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tpio_top u_dut (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
    .ch1PinAIn(pinIn), .ch1PinAOut(pinOut), .ch1PinAOe_n(pinOeN), .irq(irq));
  tpio_pin_model u_pin (.clk(clk), .devOut(pinOut), .devOeN(pinOeN), .pinIn(pinIn));

  task automatic results;
    if (errCount == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errCount++;
      results();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errCount++;
    end
  endtask

  // one-cycle strobes; a spare edge between accesses avoids double drive
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic rdChk(input string name, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    busReq <= '0;
    #1;
    chk(name, exp, rdData);
  endtask

  // compare run: timer stopped while set up, started last, one match at count 5
  task automatic cmpRun(input logic [3:0] code, input logic [1:0] e);
    wrReg(tpio_pkg::ADDR_GRA1, 16'h0005);
    wrReg(tpio_pkg::ADDR_CNT, 16'h0000);
    wrReg(tpio_pkg::ADDR_IOC_CH1, {12'h000, code});
    @(posedge clk);
    #1;
    chk("pin before match", {14'h0000, 1'b0, e[1]}, {14'h0000, pinOeN, pinOut});
    wrReg(tpio_pkg::ADDR_RUN, 16'h0001);
    repeat (12) @(posedge clk);
    wrReg(tpio_pkg::ADDR_RUN, 16'h0000);
    #1;
    chk("pin after match", {15'h0000, e[0]}, {15'h0000, pinOut});
    rdChk("match status", tpio_pkg::ADDR_STATUS, 16'h0001);
    chk("irq on match", 16'h0001, {15'h0000, irq});
    wrReg(tpio_pkg::ADDR_MASK, 16'h0000);
    #1;
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wrReg(tpio_pkg::ADDR_MASK, 16'h0001);
    wrReg(tpio_pkg::ADDR_STATUS, 16'h0007);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask

  // capture run: counter held still so the latched value is known
  task automatic capRun(input logic [3:0] code, input logic [1:0] e);
    u_pin.setLevel(1'b0);
    wrReg(tpio_pkg::ADDR_IOC_CH1, {12'h000, code});
    repeat (6) @(posedge clk);
    #1;
    chk("pin released", 16'h0001, {15'h0000, pinOeN});
    wrReg(tpio_pkg::ADDR_CNT, 16'h1234);
    wrReg(tpio_pkg::ADDR_GRA1, 16'hFFFF);
    u_pin.setLevel(1'b1);
    repeat (8) @(posedge clk);
    rdChk("rise capture", tpio_pkg::ADDR_GRA1, e[1] ? 16'h1234 : 16'hFFFF);
    wrReg(tpio_pkg::ADDR_CNT, 16'h5678);
    wrReg(tpio_pkg::ADDR_GRA1, 16'hFFFF);
    u_pin.setLevel(1'b0);
    repeat (8) @(posedge clk);
    rdChk("fall capture", tpio_pkg::ADDR_GRA1, e[0] ? 16'h5678 : 16'hFFFF);
    wrReg(tpio_pkg::ADDR_STATUS, 16'h0007);
  endtask

  initial begin
    busReq = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("pin after reset", 16'h0000, {14'h0000, pinOeN, pinOut});
    for (int a = 0; a < 7; a++) begin
      rdChk("control reset", a[3:0], 16'h0000);
    end
    rdChk("gra1 reset", tpio_pkg::ADDR_GRA1, 16'hFFFF);
    for (int a = 1; a < 4; a++) begin
      wrReg(a[3:0], 16'h00A5);
      rdChk("low control rw", a[3:0], 16'h00A5);
      wrReg(a[3:0], 16'h005A);
      rdChk("low control rw", a[3:0], 16'h005A);
    end
    for (int a = 4; a < 7; a++) begin
      wrReg(a[3:0], 16'h00FF);
      rdChk("ch5 control", a[3:0], 16'h001F);
    end
    wrReg(4'hF, 16'h1234);
    rdChk("unmapped", 4'hF, 16'h0000);
    wrReg(tpio_pkg::ADDR_MASK, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      cmpRun(cmpCode[i], cmpExp[i]);
    end
    for (int i = 0; i < 6; i++) begin
      capRun(capCode[i], capExp[i]);
    end
    // channel 0 match, then channel 0 capture, drives the capture in place of the pin
    for (int m = 0; m < 2; m++) begin
      wrReg(tpio_pkg::ADDR_MODE0, 16'(m));
      rdChk("ch0 mode", tpio_pkg::ADDR_MODE0, 16'(m));
      wrReg(tpio_pkg::ADDR_IOC_CH1, 16'h000C);
      wrReg(tpio_pkg::ADDR_GRA0, 16'h0010);
      wrReg(tpio_pkg::ADDR_CNT, 16'h0000);
      wrReg(tpio_pkg::ADDR_GRA1, 16'hFFFF);
      wrReg(tpio_pkg::ADDR_RUN, 16'h0001);
      repeat (30) @(posedge clk);
      wrReg(tpio_pkg::ADDR_RUN, 16'h0000);
      rdChk("ch0 event status", tpio_pkg::ADDR_STATUS, 16'h0006);
      chk("irq stays masked", 16'h0000, {15'h0000, irq});
      rdChk("ch0 capture", tpio_pkg::ADDR_GRA1, 16'h0010);
      wrReg(tpio_pkg::ADDR_STATUS, 16'h0007);
    end
    results();
  end
endmodule

// ===== tb/tpio_pin_model.sv
module tpio_pin_model (
  // clock
  input wire logic clk,
  // device side of the line
  input wire logic devOut,
  input wire logic devOeN,
  // level seen by the device input
  output logic pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic extLevel = 1'b0;
  // the source moves just after an edge; the device still has to synchronise it
  task automatic setLevel(input logic lvl);
    @(posedge clk);
    extLevel <= lvl;
  endtask
  // device owns the line while its enable is low, else the external source
  assign pinIn = devOeN ? extLevel : devOut;
endmodule
